// file: logic/bcc_regs.vh
// constants for the bridge correction and clipping core
`ifndef BCC_REGS_VH
`define BCC_REGS_VH
// apb byte offsets
`define BCC_STAGE0      8'h00
`define BCC_CTRL        8'h14
`define BCC_DUMP        8'h18
`define BCC_RAW_BR      8'h1C
`define BCC_RAW_T       8'h20
`define BCC_RESULT      8'h24
`define BCC_CUST        8'h28
`define BCC_STAGE_WORDS 5
// nonvolatile store image fields (lsb positions)
`define BCC_NV_BITS     160
`define BCC_F_GAIN_B    0
`define BCC_F_OFFS_B    16
`define BCC_F_OFFS_SIGN 30
`define BCC_F_FLIP      31
`define BCC_F_TCG       32
`define BCC_F_TCO       44
`define BCC_F_SOT       56
`define BCC_F_SOT_TGT   68
`define BCC_F_GAIN_T    70
`define BCC_F_OFFS_T    82
`define BCC_F_MODE      94
`define BCC_F_RATE      96
`define BCC_F_NEG_GAIN  98
`define BCC_F_DIAG      100
`define BCC_F_ZERO      103
`define BCC_F_UP_CLIP   105
`define BCC_F_LOW_CLIP  112
`define BCC_F_TSETL     119
`define BCC_F_CUST      131
`define BCC_NV_RST      160'h0000_0000_0000_FE00_0001_0000_0000_0000_0000_4000
// second-order targets and output modes
`define BCC_TGT_BRIDGE  2'h0
`define BCC_TGT_TCO     2'h1
`define BCC_TGT_TCG     2'h2
`define BCC_MODE_ABS    2'h1
`define BCC_MODE_DIG    2'h2
// fixed point
`define BCC_COEF_SHIFT  10
`define BCC_UNITY_GAIN  40'sh0000004000
`define BCC_SOT_BASE    40'sh0000001400
// timing
`define BCC_CLK_NS      10
`define BCC_PROG_MS     6
`define BCC_SAMPLE_US   1000
`endif

// file: logic/bcc_core.v
// bridge correction, clipping, nonvolatile image and apb slave
`include "bcc_regs.vh"
module bcc_core #(
    parameter SAMPLE_CYC = (`BCC_SAMPLE_US * 1000) / `BCC_CLK_NS,
    parameter PROG_CYC   = (`BCC_PROG_MS * 1000000) / `BCC_CLK_NS
) (
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    input  wire        clk_en_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        conv_done_i,
    input  wire        conv_temp_i,
    input  wire [13:0] conv_data_i,
    output reg         conv_start_o,
    output reg         conv_temp_o,
    output reg  [1:0]  zero_sel_o,
    output reg         bridge_swap_o,
    output reg  [13:0] corr_bridge_o,
    output reg  [7:0]  temp_out_o,
    output reg         result_valid_o,
    output reg  [11:0] dac_data_o,
    output reg         dac_load_o,
    output reg         out_absolute_o,
    output reg         out_digital_o,
    output reg         short_limit_en_o,
    output reg         nv_busy_o
);

    // ------------------------------------------------
    // saturation helper
    // ------------------------------------------------
    function [13:0] sat14;
        input signed [39:0] v;
        begin
            if (v < 40'sd0)
                sat14 = 14'h0000;
            else if (v > 40'sd16383)
                sat14 = 14'h3FFF;
            else
                sat14 = v[13:0];
        end
    endfunction

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    reg  [`BCC_NV_BITS-1:0] nv_q;
    wire [`BCC_NV_BITS-1:0] stage;
    reg  [`BCC_NV_BITS-1:0] prog_img;
    reg  [`BCC_NV_BITS-1:0] dump_sr;
    reg  [22:0]             prog_cnt;
    reg  [29:0]             rate_cnt;
    reg  [13:0]             raw_br;
    reg  [13:0]             raw_t;
    reg  signed [12:0]      dtemp;

    // ------------------------------------------------
    // field decode
    // ------------------------------------------------
    wire [15:0] gain_b   = nv_q[`BCC_F_GAIN_B +: 16];
    wire [13:0] offs_b   = nv_q[`BCC_F_OFFS_B +: 14];
    wire        offs_add = nv_q[`BCC_F_OFFS_SIGN];
    wire [11:0] tcg      = nv_q[`BCC_F_TCG +: 12];
    wire [11:0] tco      = nv_q[`BCC_F_TCO +: 12];
    wire [11:0] second_order_coeff      = nv_q[`BCC_F_SOT +: 12];
    wire [1:0]  sot_tgt  = nv_q[`BCC_F_SOT_TGT +: 2];
    wire [11:0] gain_t   = nv_q[`BCC_F_GAIN_T +: 12];
    wire [11:0] offs_t   = nv_q[`BCC_F_OFFS_T +: 12];
    wire [1:0]  rate     = nv_q[`BCC_F_RATE +: 2];
    wire        neg_gain = nv_q[`BCC_F_NEG_GAIN];
    wire [6:0]  up_clip  = nv_q[`BCC_F_UP_CLIP +: 7];
    wire [6:0]  low_clip = nv_q[`BCC_F_LOW_CLIP +: 7];
    wire [11:0] tsetl    = nv_q[`BCC_F_TSETL +: 12];
    wire [29:0] period   = SAMPLE_CYC[29:0] << {rate, 1'b0};

    // ------------------------------------------------
    // correction datapath
    // ------------------------------------------------
    reg  signed [39:0] s_dt;
    reg  signed [39:0] sot_dt;
    reg  signed [39:0] tcg_e;
    reg  signed [39:0] tco_e;
    reg  signed [39:0] gfac;
    reg  signed [39:0] bsum;
    reg  signed [39:0] gtot;
    reg  signed [39:0] zb_s;
    reg  signed [39:0] sfac;
    reg  signed [39:0] tsum;
    reg  [13:0]        braw;
    reg  [13:0]        b_sat;
    reg  [13:0]        intermediate_result;
    reg  [13:0]        corrected_output_value;
    reg  [13:0]        clipped;
    reg  [13:0]        t_corr;
    reg  [13:0]        up_thr;
    reg  [13:0]        low_thr;
    reg  [11:0]        t12;

    always @*
    begin
        braw   = neg_gain ? ~conv_data_i : conv_data_i;
        s_dt   = {{27{dtemp[12]}}, dtemp};
        sot_dt = (s_dt * $signed({{28{second_order_coeff[11]}}, second_order_coeff})) >>> `BCC_COEF_SHIFT;
        tcg_e  = $signed({{28{tcg[11]}}, tcg});
        tco_e  = $signed({{28{tco[11]}}, tco});
        case (sot_tgt)
            `BCC_TGT_TCO: tco_e = tco_e + sot_dt;
            `BCC_TGT_TCG: tcg_e = tcg_e + sot_dt;
            default: ;
        endcase
        gfac = `BCC_UNITY_GAIN + ((s_dt * tcg_e) >>> `BCC_COEF_SHIFT);
        bsum = $signed({26'h0, braw}) + ((s_dt * tco_e) >>> `BCC_COEF_SHIFT);
        if (offs_add)
            bsum = bsum + $signed({26'h0, offs_b});
        else
            bsum = bsum - $signed({26'h0, offs_b});
        b_sat = sat14(bsum);
        gtot  = ($signed({24'h0, gain_b}) * gfac) >>> 14;
        intermediate_result = sat14((gtot * $signed({26'h0, b_sat})) >>> 14);
        zb_s  = $signed({26'h0, intermediate_result});
        sfac  = `BCC_SOT_BASE + ((zb_s * $signed({{28{second_order_coeff[11]}}, second_order_coeff})) >>> 12);
        if (sot_tgt == `BCC_TGT_BRIDGE)
            corrected_output_value = sat14((zb_s * sfac) >>> 12);
        else
            corrected_output_value = intermediate_result;
        up_thr  = {2'h3, up_clip, 5'h1F};
        low_thr = {2'h0, low_clip, 5'h00};
        if (corrected_output_value > up_thr)
            clipped = up_thr;
        else if (corrected_output_value < low_thr)
            clipped = low_thr;
        else
            clipped = corrected_output_value;
        t12    = conv_data_i[13:2];
        tsum   = $signed({28'h0, t12}) + $signed({{28{offs_t[11]}}, offs_t});
        t_corr = sat14(($signed({28'h0, gain_t}) * tsum) >>> `BCC_COEF_SHIFT);
    end

    // ------------------------------------------------
    // apb decode
    // ------------------------------------------------
    wire        acc    = psel_i & penable_i & pready_o;
    wire        setup  = psel_i & ~penable_i;
    wire [5:0]  widx   = paddr_i[7:2];
    wire        is_stg = (widx < `BCC_STAGE_WORDS) && (paddr_i[1:0] == 2'h0);
    reg  [31:0] rdata;
    reg         rerr;

    always @*
    begin
        rdata = 32'h00000000;
        rerr  = 1'b0;
        if (is_stg)
            rdata = stage[widx * 32 +: 32];
        else
            case (paddr_i)
                `BCC_CTRL:   rdata = {31'h0, nv_busy_o};
                `BCC_DUMP:   rdata = {24'h0, dump_sr[7:0]};
                `BCC_RAW_BR: rdata = {18'h0, raw_br};
                `BCC_RAW_T:  rdata = {18'h0, raw_t};
                `BCC_RESULT: rdata = {8'h0, temp_out_o, 2'h0, corr_bridge_o};
                `BCC_CUST:   rdata = {8'h0, nv_q[`BCC_F_CUST +: 24]};
                default:     rerr = 1'b1;
            endcase
    end

    // ------------------------------------------------
    // staging words, one register per bus word
    // ------------------------------------------------
    localparam [`BCC_NV_BITS-1:0] NV_RST = `BCC_NV_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `BCC_STAGE_WORDS; gi = gi + 1)
        begin : g_stage
            reg [31:0] word;
            always @(posedge ref_clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                    word <= NV_RST[gi * 32 +: 32];
                else if (clk_en_i && acc && pwrite_i && is_stg && {26'h0, widx} == gi)
                    word <= pwdata_i;
            end
            assign stage[gi * 32 +: 32] = word;
        end
    endgenerate

    // ------------------------------------------------
    // bus slave and nonvolatile image
    // ------------------------------------------------
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prog_img  <= `BCC_NV_RST;
            nv_q      <= `BCC_NV_RST;
            dump_sr   <= `BCC_NV_RST;
            prog_cnt  <= 23'h000000;
            nv_busy_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pready_o  <= setup;
            prdata_o  <= setup & ~pwrite_i ? rdata : 32'h00000000;
            pslverr_o <= setup & rerr;
            if (acc && pwrite_i && paddr_i == `BCC_CTRL && pwdata_i[1])
                dump_sr <= nv_q;
            else if (acc && !pwrite_i && paddr_i == `BCC_DUMP)
                dump_sr <= {dump_sr[7:0], dump_sr[`BCC_NV_BITS-1:8]};
            if (nv_busy_o)
            begin
                if (prog_cnt == 23'h000001)
                begin
                    nv_q      <= prog_img;
                    nv_busy_o <= 1'b0;
                end
                prog_cnt <= prog_cnt - 23'h000001;
            end
            else if (acc && pwrite_i && paddr_i == `BCC_CTRL && pwdata_i[0])
            begin
                prog_cnt  <= PROG_CYC[22:0];
                prog_img  <= stage;
                nv_busy_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------
    // conversion scheduler
    // ------------------------------------------------
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rate_cnt     <= 30'h00000000;
            conv_start_o <= 1'b0;
            conv_temp_o  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            conv_start_o <= (rate_cnt == 30'h00000000);
            if (rate_cnt == 30'h00000000)
            begin
                rate_cnt    <= period - 30'h00000001;
                conv_temp_o <= ~conv_temp_o;
            end
            else
                rate_cnt <= rate_cnt - 30'h00000001;
        end
    end

    // ------------------------------------------------
    // sample capture and output stage
    // ------------------------------------------------
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            raw_br           <= 14'h0000;
            raw_t            <= 14'h0000;
            dtemp            <= 13'h0000;
            corr_bridge_o    <= 14'h0000;
            temp_out_o       <= 8'h00;
            result_valid_o   <= 1'b0;
            dac_data_o       <= 12'h000;
            dac_load_o       <= 1'b0;
            zero_sel_o       <= 2'h0;
            bridge_swap_o    <= 1'b0;
            out_absolute_o   <= 1'b0;
            out_digital_o    <= 1'b0;
            short_limit_en_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            zero_sel_o       <= nv_q[`BCC_F_ZERO +: 2];
            bridge_swap_o    <= nv_q[`BCC_F_FLIP];
            out_absolute_o   <= nv_q[`BCC_F_MODE +: 2] == `BCC_MODE_ABS;
            out_digital_o    <= nv_q[`BCC_F_MODE +: 2] == `BCC_MODE_DIG;
            short_limit_en_o <= nv_q[`BCC_F_DIAG];
            result_valid_o   <= conv_done_i & ~conv_temp_i;
            dac_load_o       <= 1'b0;
            if (conv_done_i && conv_temp_i)
            begin
                raw_t      <= conv_data_i;
                dtemp      <= $signed({1'b0, t12}) - $signed({1'b0, tsetl});
                temp_out_o <= t_corr[13:6];
            end
            if (conv_done_i && !conv_temp_i)
            begin
                raw_br        <= conv_data_i;
                corr_bridge_o <= clipped;
                if (nv_q[`BCC_F_MODE +: 2] != `BCC_MODE_DIG)
                begin
                    dac_data_o <= clipped[13:2];
                    dac_load_o <= 1'b1;
                end
            end
        end
    end

endmodule // bcc_core

// file: bench/bcc_core_asserts.sv
// assertion checker for the bridge correction core ports
module bcc_core_chk #(
    parameter int PROG_CYC   = 50,
    parameter int SAMPLE_CYC = 20
) (
    input wire        ref_clk_i,
    input wire        arst_n_i,
    input wire        clk_en_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        conv_done_i,
    input wire        conv_temp_i,
    input wire        conv_start_o,
    input wire [13:0] corr_bridge_o,
    input wire        result_valid_o,
    input wire [11:0] dac_data_o,
    input wire        dac_load_o,
    input wire        out_digital_o,
    input wire        nv_busy_o
);
    logic [31:0] busy_cnt;
    // ----------------------------------------
    // programming time counter
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            busy_cnt <= 32'h0;
        else if (nv_busy_o)
            busy_cnt <= busy_cnt + 32'h1;
        else
            busy_cnt <= 32'h0;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    apb_answer_a: assert property (psel_i && !penable_i && clk_en_i |=> pready_o)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error response malformed");
    bridge_result_a: assert property (conv_done_i && !conv_temp_i && clk_en_i |=> result_valid_o)
        else $error("bridge sample gave no result");
    temp_quiet_a: assert property (conv_done_i && conv_temp_i && clk_en_i |=> !result_valid_o)
        else $error("temperature sample gave a result");
    dac_copy_a: assert property (dac_load_o |-> dac_data_o == corr_bridge_o[13:2])
        else $error("dac word differs from result");
    dac_mode_a: assert property (dac_load_o |-> !out_digital_o)
        else $error("dac loaded in digital mode");
    prog_time_a: assert property ($fell(nv_busy_o) |-> busy_cnt == PROG_CYC)
        else $error("programming time wrong");
    start_gap_a: assert property (conv_start_o |=> (!conv_start_o) [*8])
        else $error("conversions started too close");
    cover property (result_valid_o);
    cover property ($fell(nv_busy_o));
    cover property (pslverr_o);
    cover property (dac_load_o);
endmodule // bcc_core_chk
bind bcc_core bcc_core_chk #(.PROG_CYC(PROG_CYC), .SAMPLE_CYC(SAMPLE_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i), .conv_start_o(conv_start_o),
    .corr_bridge_o(corr_bridge_o), .result_valid_o(result_valid_o), .dac_data_o(dac_data_o),
    .dac_load_o(dac_load_o), .out_digital_o(out_digital_o), .nv_busy_o(nv_busy_o));

// file: bench/bcc_conv_model.sv
// behavioural converter front end answering conversion starts
module bcc_conv_model #(
    parameter int DLY = 3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic        kind_i,
    input  wire logic [13:0] bridge_i,
    input  wire logic [13:0] temp_i,
    output logic             done_o,
    output logic             kind_o,
    output logic [13:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt;
    logic kind_q;
    // data lines toggle outside the result cycle so stale values never match
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            cnt <= 0;
            kind_q <= 1'b0;
            done_o <= 1'b0;
            kind_o <= 1'b0;
            data_o <= 14'h0000;
        end
        else
        begin
            done_o <= 1'b0;
            kind_o <= ~kind_o;
            data_o <= ~data_o;
            if (start_i)
            begin
                cnt <= DLY;
                kind_q <= kind_i;
            end
            else if (cnt == 1)
            begin
                cnt <= 0;
                done_o <= 1'b1;
                kind_o <= kind_q;
                data_o <= kind_q ? temp_i : bridge_i;
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
endmodule // bcc_conv_model

// file: bench/bcc_core_tb.sv
// self-checking bench for the bridge correction core
`include "bcc_regs.vh"
module bcc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd_q;
    logic [13:0] br_val = 0, t_val = 0, conv_data, corr;
    logic [11:0] dac_data;
    logic [7:0] temp_out;
    logic [1:0] zero_sel;
    logic [159:0] m;
    logic pready, pslverr, done, kind, start, kind_req, swap, valid, dac_load, absol, digi;
    logic slim, busy, err_q;
    int error_cnt = 0, tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    bcc_core #(.SAMPLE_CYC(20), .PROG_CYC(50)) u_dut (
        .ref_clk_i(ref_clk), .arst_n_i(arst_n), .clk_en_i(clk_en), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .conv_done_i(done),
        .conv_temp_i(kind), .conv_data_i(conv_data), .conv_start_o(start),
        .conv_temp_o(kind_req), .zero_sel_o(zero_sel), .bridge_swap_o(swap),
        .corr_bridge_o(corr), .temp_out_o(temp_out), .result_valid_o(valid),
        .dac_data_o(dac_data), .dac_load_o(dac_load), .out_absolute_o(absol),
        .out_digital_o(digi), .short_limit_en_o(slim), .nv_busy_o(busy));
    bcc_conv_model u_conv (.clk_i(ref_clk), .rst_n_i(arst_n), .start_i(start),
        .kind_i(kind_req), .bridge_i(br_val), .temp_i(t_val), .done_o(done),
        .kind_o(kind), .data_o(conv_data));
    task automatic finish_test;
        $display("errors %0d in %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
        chk(32'(err_q), 32'h0);
    endtask
    task automatic wait_res;
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (valid !== 1'b1 && n < 200);
        chk(32'(valid), 32'h1);
    endtask
    task automatic set_img(input logic [159:0] img);
        int n;
        for (int i = 0; i < `BCC_STAGE_WORDS; i++)
            apb(1'b1, `BCC_STAGE0 + 8'(4 * i), img[32 * i +: 32]);
        apb(1'b1, `BCC_CTRL, 32'h1);
        rd(`BCC_CTRL, 32'h1);
        n = 0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(32'(busy), 32'h0);
        wait_res;
        wait_res;
    endtask
    function automatic logic [159:0] mk(logic [13:0] off, logic sg, logic [11:0] ts, tco, second_order_coeff,
                                        logic [1:0] tg, logic [6:0] up, lo);
        mk = `BCC_NV_RST;
        mk[`BCC_F_OFFS_B +: 14] = off;
        mk[`BCC_F_OFFS_SIGN] = sg;
        mk[`BCC_F_TSETL +: 12] = ts;
        mk[`BCC_F_TCO +: 12] = tco;
        mk[`BCC_F_SOT +: 12] = second_order_coeff;
        mk[`BCC_F_SOT_TGT +: 2] = tg;
        mk[`BCC_F_UP_CLIP +: 7] = up;
        mk[`BCC_F_LOW_CLIP +: 7] = lo;
    endfunction
    task automatic run(input logic [159:0] img, input logic [13:0] rt, rb, eb,
                       input logic [7:0] et);
        t_val <= rt;
        br_val <= rb;
        set_img(img);
        chk(32'(corr), 32'(eb));
        chk(32'(temp_out), 32'(et));
        chk(32'(dac_data), 32'(eb[13:2]));
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(`BCC_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err_q), 32'h1);
        chk(rd_q, 32'h0);
        run(mk(0, 0, 0, 0, 0, 0, 7'h7F, 0), 0, 14'h1000, 14'h1400, 0);
        rd(`BCC_RAW_BR, 32'h1000);
        rd(`BCC_RESULT, 32'h00001400);
        run(mk(0, 0, 0, 0, 0, 0, 7'h7F, 0), 0, 14'h3FFF, 14'h3FFF, 0);
        run(mk(0, 0, 0, 0, 0, 0, 7'h00, 0), 0, 14'h3000, 14'h301F, 0);
        run(mk(0, 0, 0, 0, 0, 0, 7'h7F, 7'h7F), 0, 14'h0100, 14'h0FE0, 0);
        run(mk(14'h100, 0, 0, 0, 0, 0, 7'h7F, 0), 0, 14'h1000, 14'h12C0, 0);
        run(mk(14'h100, 1, 0, 0, 0, 0, 7'h7F, 0), 0, 14'h1000, 14'h1540, 0);
        run(mk(14'h100, 0, 0, 0, 0, 0, 7'h7F, 0), 0, 14'h0050, 14'h0000, 0);
        run(mk(0, 0, 12'h100, 12'h400, 0, 0, 7'h7F, 0), 14'h600, 14'h1000, 14'h14A0, 6);
        run(mk(0, 0, 0, 0, 12'h400, 0, 7'h7F, 0), 0, 14'h1000, 14'h1800, 0);
        run(mk(0, 0, 12'h100, 0, 12'h400, 1, 7'h7F, 0), 14'h600, 14'h1000, 14'h1010, 6);
        run(mk(0, 0, 12'h100, 0, 12'h400, 2, 7'h7F, 0), 14'h600, 14'h1000, 14'h1004, 6);
        m = mk(0, 0, 0, 0, 0, 0, 7'h7F, 0);
        m[`BCC_F_GAIN_T +: 12] = 12'h800;
        m[`BCC_F_OFFS_T +: 12] = 12'h010;
        run(m, 14'h2A5F, 14'h1000, 14'h1400, 8'h55);
        rd(`BCC_RAW_T, 32'h00002A5F);
        rd(`BCC_RESULT, 32'h00551400);
        m[`BCC_F_MODE +: 2] = `BCC_MODE_ABS;
        m[`BCC_F_DIAG] = 1'b1;
        m[`BCC_F_ZERO +: 2] = 2'h3;
        m[`BCC_F_FLIP] = 1'b1;
        m[`BCC_F_CUST +: 24] = 24'hA5C35A;
        set_img(m);
        chk(32'(absol), 32'h1);
        chk(32'(slim), 32'h1);
        chk(32'(zero_sel), 32'h3);
        chk(32'(swap), 32'h1);
        rd(`BCC_CUST, 32'h00A5C35A);
        apb(1'b1, `BCC_CTRL, 32'h2);
        for (int i = 0; i < 4; i++)
            rd(`BCC_DUMP, 32'(m[8 * i +: 8]));
        m[`BCC_F_MODE +: 2] = `BCC_MODE_DIG;
        set_img(m);
        chk(32'(digi), 32'h1);
        finish_test;
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        finish_test;
    end
endmodule // bcc_core_tb
